// ### include/tpf_cfg.svh
// Register indexes, field layouts and codes of the timer pending flag block
`ifndef TPF_CFG_SVH
`define TPF_CFG_SVH

`define TPF_ADDR_W        18
`define TPF_IDX_PRIO_LO   16'hff21
`define TPF_IDX_EN_LO     16'hff25
`define TPF_IDX_PEND_LO   16'hff29
`define TPF_IDX_PRIO_HI   16'hff2a
`define TPF_IDX_EN_HI     16'hff2c
`define TPF_IDX_PEND_HI   16'hff2e
`define TPF_IDX_STAT      16'hff30
`define TPF_IDX_MASK      16'hff31

`define TPF_PRIO_LO_LSB   2
`define TPF_PRIO_HI_LSB   0
`define TPF_PRIO_LO_MASK  8'h3c
`define TPF_PRIO_HI_MASK  8'h0f
`define TPF_PEND_RST      8'h00
`define TPF_STAT_MASK     8'h0f

`define TPF_STAT_LO       0
`define TPF_STAT_HI       1
`define TPF_STAT_ACK      2
`define TPF_STAT_RERAISE  3

`define TPF_VEC_LO_BASE   16'h0016
`define TPF_VEC_HI_BASE   16'h003c

`define TPF_RESP_OKAY     2'b00
`define TPF_RESP_SLVERR   2'b10

`endif

// ### include/tpf_pkg.sv
// Types shared by the timer pending flag block
`include "tpf_cfg.svh"

package tpf_pkg;

  typedef enum logic [3:0] {
    REG_NONE,
    REG_PRIO_LO,
    REG_EN_LO,
    REG_PEND_LO,
    REG_PRIO_HI,
    REG_EN_HI,
    REG_PEND_HI,
    REG_STAT,
    REG_MASK
  } tpf_reg_t;

  typedef struct packed {
    logic                   awvalid;
    logic [`TPF_ADDR_W-1:0] awaddr;
    logic                   wvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bready;
    logic                   arvalid;
    logic [`TPF_ADDR_W-1:0] araddr;
    logic                   rready;
  } tpf_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tpf_axi_rsp_t;

  typedef struct packed {
    logic                   meta;
    logic                   out;
  } tpf_rsync_t;

  typedef struct packed {
    logic [7:0]             pendLo;
    logic [7:0]             pendHi;
    logic [7:0]             enLo;
    logic [7:0]             enHi;
    logic [7:0]             prioLo;
    logic [7:0]             prioHi;
    logic [7:0]             stat;
    logic [7:0]             mask;
    logic                   awHeld;
    logic [`TPF_ADDR_W-1:0] awAddr;
    logic                   wHeld;
    logic [31:0]            wData;
    logic [3:0]             wStrb;
    tpf_axi_rsp_t           rsp;
    logic                   irqReq;
    logic [1:0]             irqLevel;
    logic [15:0]            vecAddr;
    logic                   irq;
  } tpf_state_t;

endpackage

// ### hw/tpf_rst_sync.sv
// Reset release synchroniser: asserts at once, releases after two edges
module tpf_rst_sync
(
  input  wire logic ref_clk,
  input  wire logic rstn,
  output wire logic rstSyncN
);

  tpf_pkg::tpf_rsync_t s_q;
  tpf_pkg::tpf_rsync_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.meta = 1'b1;
    s_d.out  = s_q.meta;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rstSyncN = s_q.out;

endmodule

// ### hw/tpf_vector.sv
// Picks the winning timer request and forms its two-byte vector address
module tpf_vector
(
  input  wire logic [15:0] req,
  input  wire logic [7:0]  prioPairs,
  output logic             winValid,
  output logic [1:0]       winLevel,
  output logic [15:0]      winVec
);

  function automatic logic [15:0] vecOf(input logic [3:0] i);
    logic [15:0] off;
    off = {12'h000, i[2:0], 1'b0};
    if (i[3])
      return `TPF_VEC_HI_BASE + off;
    else
      return `TPF_VEC_LO_BASE + off;
  endfunction

  always_comb
  begin
    logic [1:0] lvl;
    lvl      = 2'h0;
    winValid = 1'b0;
    winLevel = 2'h0;
    winVec   = 16'h0000;
    for (int i = 15; i >= 0; i--)
    begin
      lvl = prioPairs[2 * (i / 4) +: 2];
      if (req[i] && (!winValid || lvl >= winLevel))
      begin
        winValid = 1'b1;
        winLevel = lvl;
        winVec   = vecOf(4'(i));
      end
    end
  end

endmodule

// ### hw/tpf_top.sv
// Timer pending flags, enables, priorities and request logic
//
// Function
// - Channels 0 to 3 put underflow in bit 2n and match in 2n+1 of a byte.
// - Channels 4 to 7 keep the same pairing in a second byte.
// - An underflow sets its channel's flag, which reads one until cleared.
// - A compare match sets its channel's flag, held until software clears it.
// - Writing one clears a flag bit, writing zero leaves it alone.
// - An irqReq still pending at return from exception sets the reraise bit in stat; irq follows if mask bit 3 is set.
// - A pending request is offered again once the CPU mask drops below it.
// - The exception vector is two bytes with no bank part.
// - A flag drives irqReq only while its enable bit is one; irq follows stat and mask and ignores enables.
// - Each timer event has its own fixed vector address.
`include "tpf_cfg.svh"

module tpf_top
(
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire logic [7:0]            underflowEvt,
  input  wire logic [7:0]            matchEvt,
  input  wire logic [1:0]            cpuPrio,
  input  wire logic                  cpuAck,
  input  wire logic                  retEvt,
  input  wire tpf_pkg::tpf_axi_req_t axiReq,
  output tpf_pkg::tpf_axi_rsp_t      axiRsp,
  output logic                       irqReq,
  output logic [1:0]                 irqLevel,
  output logic [15:0]                vecAddr,
  output logic                       irq
);

  tpf_pkg::tpf_state_t s_q;
  tpf_pkg::tpf_state_t s_d;
  logic                rstSyncN;
  logic                winValid;
  logic [1:0]          winLevel;
  logic [15:0]         winVec;
  logic                doWrite;
  tpf_pkg::tpf_reg_t   wrReg;
  logic [7:0]          wrByte;
  logic                wrLane;
  logic                doRead;
  tpf_pkg::tpf_reg_t   rdReg;

  function automatic tpf_pkg::tpf_reg_t decode(
    input logic [`TPF_ADDR_W-1:0] a
  );
    tpf_pkg::tpf_reg_t r;
    r = tpf_pkg::REG_NONE;
    if (a[1:0] == 2'h0)
    begin
      unique case (a[`TPF_ADDR_W-1:2])
        `TPF_IDX_PRIO_LO: r = tpf_pkg::REG_PRIO_LO;
        `TPF_IDX_EN_LO:   r = tpf_pkg::REG_EN_LO;
        `TPF_IDX_PEND_LO: r = tpf_pkg::REG_PEND_LO;
        `TPF_IDX_PRIO_HI: r = tpf_pkg::REG_PRIO_HI;
        `TPF_IDX_EN_HI:   r = tpf_pkg::REG_EN_HI;
        `TPF_IDX_PEND_HI: r = tpf_pkg::REG_PEND_HI;
        `TPF_IDX_STAT:    r = tpf_pkg::REG_STAT;
        `TPF_IDX_MASK:    r = tpf_pkg::REG_MASK;
        default:          r = tpf_pkg::REG_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic logic [7:0] interleave(
    input logic [3:0] u,
    input logic [3:0] m
  );
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 4; k++)
    begin
      r[2 * k]     = u[k];
      r[2 * k + 1] = m[k];
    end
    return r;
  endfunction

  tpf_rst_sync u_rst
  (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .rstSyncN (rstSyncN)
  );

  tpf_vector u_vec
  (
    .req       ({s_q.pendHi & s_q.enHi, s_q.pendLo & s_q.enLo}),
    .prioPairs ({s_q.prioHi[`TPF_PRIO_HI_LSB +: 4],
                 s_q.prioLo[`TPF_PRIO_LO_LSB +: 4]}),
    .winValid  (winValid),
    .winLevel  (winLevel),
    .winVec    (winVec)
  );

  always_comb
  begin
    logic                   awTake;
    logic                   wTake;
    logic                   arTake;
    logic [`TPF_ADDR_W-1:0] aAddr;
    logic [31:0]            wD;
    logic [3:0]             wS;
    logic [7:0]             setLo;
    logic [7:0]             setHi;
    logic [7:0]             clrLo;
    logic [7:0]             clrHi;
    logic [7:0]             setStat;
    logic [7:0]             clrStat;
    logic [7:0]             rdByte;
    s_d     = s_q;
    awTake  = axiReq.awvalid && s_q.rsp.awready;
    wTake   = axiReq.wvalid && s_q.rsp.wready;
    arTake  = axiReq.arvalid && s_q.rsp.arready;
    aAddr   = s_q.awHeld ? s_q.awAddr : axiReq.awaddr;
    wD      = s_q.wHeld ? s_q.wData : axiReq.wdata;
    wS      = s_q.wHeld ? s_q.wStrb : axiReq.wstrb;
    clrLo   = 8'h00;
    clrHi   = 8'h00;
    clrStat = 8'h00;
    setStat = 8'h00;
    rdByte  = 8'h00;
    doWrite = (s_q.awHeld || awTake) && (s_q.wHeld || wTake);
    wrReg   = decode(aAddr);
    wrByte  = wD[7:0];
    wrLane  = wS[0];
    doRead  = arTake;
    rdReg   = decode(axiReq.araddr);
    setLo   = interleave(underflowEvt[3:0], matchEvt[3:0]);
    setHi   = interleave(underflowEvt[7:4], matchEvt[7:4]);

    if (awTake)
    begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = axiReq.awaddr;
    end
    if (wTake)
    begin
      s_d.wHeld = 1'b1;
      s_d.wData = axiReq.wdata;
      s_d.wStrb = axiReq.wstrb;
    end
    if (s_q.rsp.bvalid && axiReq.bready)
      s_d.rsp.bvalid = 1'b0;
    if (doWrite)
    begin
      s_d.awHeld    = 1'b0;
      s_d.wHeld     = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = (wrReg == tpf_pkg::REG_NONE) ?
                       `TPF_RESP_SLVERR : `TPF_RESP_OKAY;
      if (wrLane)
      begin
        unique case (wrReg)
          tpf_pkg::REG_PRIO_LO: s_d.prioLo = wrByte & `TPF_PRIO_LO_MASK;
          tpf_pkg::REG_PRIO_HI: s_d.prioHi = wrByte & `TPF_PRIO_HI_MASK;
          tpf_pkg::REG_EN_LO:   s_d.enLo   = wrByte;
          tpf_pkg::REG_EN_HI:   s_d.enHi   = wrByte;
          tpf_pkg::REG_PEND_LO: clrLo      = wrByte;
          tpf_pkg::REG_PEND_HI: clrHi      = wrByte;
          tpf_pkg::REG_MASK:    s_d.mask   = wrByte & `TPF_STAT_MASK;
          tpf_pkg::REG_STAT,
          tpf_pkg::REG_NONE:    s_d.mask   = s_q.mask;
        endcase
      end
    end

    if (s_q.rsp.rvalid && axiReq.rready)
      s_d.rsp.rvalid = 1'b0;
    if (arTake)
    begin
      unique case (rdReg)
        tpf_pkg::REG_PRIO_LO: rdByte = s_q.prioLo;
        tpf_pkg::REG_PRIO_HI: rdByte = s_q.prioHi;
        tpf_pkg::REG_EN_LO:   rdByte = s_q.enLo;
        tpf_pkg::REG_EN_HI:   rdByte = s_q.enHi;
        tpf_pkg::REG_PEND_LO: rdByte = s_q.pendLo;
        tpf_pkg::REG_PEND_HI: rdByte = s_q.pendHi;
        tpf_pkg::REG_MASK:    rdByte = s_q.mask;
        tpf_pkg::REG_STAT:
        begin
          rdByte  = s_q.stat;
          clrStat = s_q.stat;
        end
        tpf_pkg::REG_NONE:    rdByte = 8'h00;
      endcase
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata  = {24'h000000, rdByte};
      s_d.rsp.rresp  = (rdReg == tpf_pkg::REG_NONE) ?
                       `TPF_RESP_SLVERR : `TPF_RESP_OKAY;
    end

    setStat[`TPF_STAT_LO]      = |(setLo & ~s_q.pendLo);
    setStat[`TPF_STAT_HI]      = |(setHi & ~s_q.pendHi);
    setStat[`TPF_STAT_ACK]     = cpuAck;
    setStat[`TPF_STAT_RERAISE] = retEvt && s_q.irqReq;

    s_d.pendLo = (s_q.pendLo & ~clrLo) | setLo;
    s_d.pendHi = (s_q.pendHi & ~clrHi) | setHi;
    s_d.stat   = (s_q.stat & ~clrStat) | setStat;
    s_d.irq    = |(s_d.stat & s_d.mask);

    s_d.irqReq   = winValid && (winLevel > cpuPrio);
    s_d.irqLevel = winLevel;
    s_d.vecAddr  = winVec;

    s_d.rsp.awready = !s_d.awHeld && !s_d.rsp.bvalid;
    s_d.rsp.wready  = !s_d.wHeld && !s_d.rsp.bvalid;
    s_d.rsp.arready = !s_d.rsp.rvalid;
  end

  always_ff @(posedge ref_clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign axiRsp   = s_q.rsp;
  assign irqReq   = s_q.irqReq;
  assign irqLevel = s_q.irqLevel;
  assign vecAddr  = s_q.vecAddr;
  assign irq      = s_q.irq;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstSyncN);

  low_layout_a: assert property (
    underflowEvt[1] |=> s_q.pendLo[2])
    else $error("underflow 1 not in bit 2");

  high_layout_a: assert property (
    matchEvt[5] |=> s_q.pendHi[3])
    else $error("match 5 not in high bit 3");

  under_sticky_a: assert property (
    underflowEvt[0] ##1 !(doWrite && wrLane && wrByte[0]
      && wrReg == tpf_pkg::REG_PEND_LO) |=> s_q.pendLo[0])
    else $error("underflow flag not kept");

  match_set_a: assert property (
    matchEvt[0] |=> s_q.pendLo[1])
    else $error("match flag not set");

  one_clears_a: assert property (
    doWrite && wrLane && wrReg == tpf_pkg::REG_PEND_HI && wrByte[7]
      && !matchEvt[7] |=> !s_q.pendHi[7])
    else $error("write one did not clear");

  zero_keeps_a: assert property (
    doWrite && wrReg == tpf_pkg::REG_PEND_LO && !wrByte[0]
      && s_q.pendLo[0] |=> s_q.pendLo[0])
    else $error("write zero changed flag");

  set_wins_a: assert property (
    doWrite && wrLane && wrReg == tpf_pkg::REG_PEND_LO && wrByte[0]
      && underflowEvt[0] |=> s_q.pendLo[0])
    else $error("clear beat set");

  reraise_a: assert property (
    retEvt && s_q.irqReq && s_q.mask[`TPF_STAT_RERAISE]
      |=> s_q.stat[`TPF_STAT_RERAISE] ##1 s_q.irq)
    else $error("return with pending not flagged");

  enable_gate_a: assert property (
    (s_q.pendLo & s_q.enLo) == 8'h00 && (s_q.pendHi & s_q.enHi) == 8'h00
      |=> !s_q.irqReq)
    else $error("request without enabled flag");

  level_mask_a: assert property (
    s_q.irqReq |-> s_q.irqLevel > $past(cpuPrio))
    else $error("request not above CPU mask");

  vector_map_a: assert property (
    s_q.pendLo == 8'h01 && s_q.enLo[0] && s_q.pendHi == 8'h00
      |=> s_q.vecAddr == `TPF_VEC_LO_BASE)
    else $error("channel 0 underflow vector wrong");

  high_vector_a: assert property (
    (s_q.pendLo & s_q.enLo) == 8'h00 && (s_q.pendHi & s_q.enHi) == 8'h01
      |=> s_q.vecAddr == `TPF_VEC_HI_BASE)
    else $error("channel 4 underflow vector wrong");

  low_match_a: assert property (
    matchEvt[3] |=> s_q.pendLo[7])
    else $error("match 3 not in bit 7");

  under_high_a: assert property (
    underflowEvt[4] |=> s_q.pendHi[0])
    else $error("underflow 4 flag not set");

  match_hold_a: assert property (
    s_q.pendHi[1] && !(doWrite && wrLane && wrByte[1]
      && wrReg == tpf_pkg::REG_PEND_HI) |=> s_q.pendHi[1])
    else $error("match flag dropped without clear");

  low_clear_a: assert property (
    doWrite && wrLane && wrReg == tpf_pkg::REG_PEND_LO && wrByte[3]
      && !matchEvt[1] |=> !s_q.pendLo[3])
    else $error("write one did not clear low flag");

  level_pass_a: assert property (
    winValid && winLevel > cpuPrio |=> s_q.irqReq)
    else $error("request above CPU mask not raised");

  vec_even_a: assert property (
    s_q.irqReq |-> !s_q.vecAddr[0])
    else $error("vector address not word aligned");

  reset_clear_a: assert property (
    $rose(rstSyncN) |-> s_q.pendLo == `TPF_PEND_RST
      && s_q.pendHi == `TPF_PEND_RST)
    else $error("flags not clear after reset");

  ack_stat_a: assert property (
    cpuAck |=> s_q.stat[`TPF_STAT_ACK])
    else $error("accept not flagged in status");

  underflow_req_c: cover property (
    underflowEvt[0] ##2 s_q.irqReq);
  w1c_clear_c: cover property (
    doWrite && wrReg == tpf_pkg::REG_PEND_LO ##1 s_q.pendLo == 8'h00);
  reraise_c: cover property (
    retEvt && s_q.irqReq);
  stat_read_c: cover property (
    doRead && rdReg == tpf_pkg::REG_STAT && s_q.stat != 8'h00);

endmodule

// ### verif/tpf_cpu_model.sv
// Behavioural timer channels and CPU core facing the request logic
module tpf_cpu_model
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] fireU,
  input  wire logic [7:0] fireM,
  input  wire logic       irqReq,
  output logic [7:0]      underflowEvt,
  output logic [7:0]      matchEvt,
  output logic            cpuAck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seenQ;
  initial
  begin
    underflowEvt = 8'h00;
    matchEvt = 8'h00;
    cpuAck = 1'b0;
    seenQ = 1'b0;
  end
  always @(posedge ref_clk)
  begin
    underflowEvt <= fireU;
    matchEvt <= fireM;
  end
  always @(posedge ref_clk)
  begin
    cpuAck <= irqReq & ~seenQ;
    seenQ <= irqReq;
  end
endmodule

// ### verif/tb_timer_irq_pending_flags.sv
// Self-checking bench of the timer pending flag block
`include "tpf_cfg.svh"
`define CHK(got, exp) \
  begin \
    cmpCount++; \
    if ((got) !== (exp)) \
    begin \
      badCount++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module tb_timer_irq_pending_flags;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk;
  logic                  rstn;
  logic [7:0]            fireU;
  logic [7:0]            fireM;
  logic [1:0]            cpuPrio;
  logic                  retEvt;
  tpf_pkg::tpf_axi_req_t axiReq;
  tpf_pkg::tpf_axi_rsp_t axiRsp;
  logic                  irqReq;
  logic [1:0]            irqLevel;
  logic [15:0]           vecAddr;
  logic                  irq;
  logic [7:0]            underflowEvt;
  logic [7:0]            matchEvt;
  logic                  cpuAck;
  logic [33:0]           expQ[$];
  logic [1:0]            expB[$];
  int                    badCount;
  int                    cmpCount;
  logic [7:0]            rnd;
  logic [7:0]            u;
  logic [7:0]            m;

  tpf_top i_tpf_top (.ref_clk(ref_clk), .rstn(rstn),
    .underflowEvt(underflowEvt), .matchEvt(matchEvt), .cpuPrio(cpuPrio),
    .cpuAck(cpuAck), .retEvt(retEvt), .axiReq(axiReq), .axiRsp(axiRsp),
    .irqReq(irqReq), .irqLevel(irqLevel), .vecAddr(vecAddr), .irq(irq));
  tpf_cpu_model i_tpf_cpu_model (.ref_clk(ref_clk), .fireU(fireU),
    .fireM(fireM), .irqReq(irqReq), .underflowEvt(underflowEvt),
    .matchEvt(matchEvt), .cpuAck(cpuAck));

  function automatic logic [7:0] lfsrNext(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  function automatic logic [7:0] pairUp(input logic [3:0] uf,
                                        input logic [3:0] mf);
    logic [7:0] r;
    for (int n = 0; n < 4; n++)
    begin
      r[2*n] = uf[n];
      r[2*n+1] = mf[n];
    end
    return r;
  endfunction

  task automatic regWrite(input logic [15:0] idx, input logic [7:0] data,
                          input logic [1:0] resp);
    int n;
    logic done;
    expB.push_back(resp);
    @(posedge ref_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= {idx, 2'b00};
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= {24'h000000, data};
    axiReq.wstrb <= 4'h1;
    axiReq.bready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done && n < 50)
    begin
      @(posedge ref_clk);
      n++;
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiReq.bready && axiRsp.bvalid)
      begin
        axiReq.bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) badCount++;
  endtask

  task automatic regRead(input logic [15:0] idx, input logic [7:0] data,
                         input logic [1:0] resp);
    int n;
    logic done;
    expQ.push_back({resp, 24'h000000, data});
    @(posedge ref_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= {idx, 2'b00};
    axiReq.rready <= 1'b1;
    done = 1'b0;
    n = 0;
    while (!done && n < 50)
    begin
      @(posedge ref_clk);
      n++;
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiReq.rready && axiRsp.rvalid)
      begin
        axiReq.rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) badCount++;
  endtask

  task automatic fire(input logic [7:0] uf, input logic [7:0] mf);
    @(posedge ref_clk);
    fireU <= uf;
    fireM <= mf;
    @(posedge ref_clk);
    fireU <= 8'h00;
    fireM <= 8'h00;
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge ref_clk)
    if (axiReq.rready && axiRsp.rvalid)
    begin
      if (expQ.size() == 0)
        badCount++;
      else
        `CHK({axiRsp.rresp, axiRsp.rdata}, expQ.pop_front())
    end

  always @(posedge ref_clk)
    if (axiReq.bready && axiRsp.bvalid)
    begin
      if (expB.size() == 0)
        badCount++;
      else
        `CHK(axiRsp.bresp, expB.pop_front())
    end

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    badCount++;
    print_verdict();
  end

  initial
  begin
    rstn = 1'b0;
    fireU = 8'h00;
    fireM = 8'h00;
    cpuPrio = 2'b00;
    retEvt = 1'b0;
    axiReq = '0;
    rnd = 8'h42;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    regRead(`TPF_IDX_PEND_LO, 8'h00, `TPF_RESP_OKAY);
    regRead(`TPF_IDX_PEND_HI, 8'h00, `TPF_RESP_OKAY);
    regRead(16'h0100, 8'h00, `TPF_RESP_SLVERR);
    regWrite(16'h0100, 8'hff, `TPF_RESP_SLVERR);
    $display("test reset values done");
    regWrite(`TPF_IDX_MASK, 8'h09, `TPF_RESP_OKAY);
    regRead(`TPF_IDX_MASK, 8'h09, `TPF_RESP_OKAY);
    rnd = lfsrNext(rnd);
    u = rnd | 8'h11;
    rnd = lfsrNext(rnd);
    m = rnd;
    fire(u, m);
    `CHK(irq, 1'b1)
    regRead(`TPF_IDX_PEND_LO, pairUp(u[3:0], m[3:0]), `TPF_RESP_OKAY);
    regRead(`TPF_IDX_PEND_HI, pairUp(u[7:4], m[7:4]), `TPF_RESP_OKAY);
    regRead(`TPF_IDX_STAT, 8'h03, `TPF_RESP_OKAY);
    regRead(`TPF_IDX_STAT, 8'h00, `TPF_RESP_OKAY);
    `CHK(irq, 1'b0)
    fire(8'h20, 8'h00);
    `CHK(irq, 1'b0)
    regRead(`TPF_IDX_STAT, 8'h02, `TPF_RESP_OKAY);
    $display("test flag layout done");
    rnd = lfsrNext(rnd);
    regWrite(`TPF_IDX_PEND_LO, rnd, `TPF_RESP_OKAY);
    regRead(`TPF_IDX_PEND_LO, pairUp(u[3:0], m[3:0]) & ~rnd,
            `TPF_RESP_OKAY);
    regWrite(`TPF_IDX_PEND_LO, 8'hff, `TPF_RESP_OKAY);
    regWrite(`TPF_IDX_PEND_HI, 8'hff, `TPF_RESP_OKAY);
    regRead(`TPF_IDX_PEND_HI, 8'h00, `TPF_RESP_OKAY);
    $display("test write one clear done");
    regWrite(`TPF_IDX_PRIO_LO, 8'hff, `TPF_RESP_OKAY);
    regRead(`TPF_IDX_PRIO_LO, 8'h3c, `TPF_RESP_OKAY);
    regWrite(`TPF_IDX_EN_LO, 8'h03, `TPF_RESP_OKAY);
    fire(8'h00, 8'h04);
    `CHK(irqReq, 1'b0)
    fire(8'h00, 8'h01);
    `CHK(irqReq, 1'b1)
    `CHK(vecAddr, 16'h0018)
    `CHK(irqLevel, 2'b11)
    fire(8'h01, 8'h00);
    `CHK(vecAddr, `TPF_VEC_LO_BASE)
    @(posedge ref_clk);
    cpuPrio <= 2'b11;
    repeat (3) @(posedge ref_clk);
    `CHK(irqReq, 1'b0)
    cpuPrio <= 2'b10;
    repeat (3) @(posedge ref_clk);
    `CHK(irqReq, 1'b1)
    retEvt <= 1'b1;
    @(posedge ref_clk);
    retEvt <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(irqReq, 1'b1)
    regWrite(`TPF_IDX_PEND_LO, 8'h03, `TPF_RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    `CHK(irqReq, 1'b0)
    regRead(`TPF_IDX_STAT, 8'h0d, `TPF_RESP_OKAY);
    regWrite(`TPF_IDX_PRIO_HI, 8'h0f, `TPF_RESP_OKAY);
    regWrite(`TPF_IDX_EN_HI, 8'h80, `TPF_RESP_OKAY);
    fire(8'h00, 8'h80);
    `CHK(vecAddr, 16'h004a)
    $display("test requests done");
    print_verdict();
  end
endmodule
